// file: bench/cac_charge_counters_assertions.sv
// assertion checker for the charge accounting counters
`timescale 1ns/1ps
`default_nettype none
module cac_charge_counters_chk import cac_pkg::*; (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic [1:0]  display_control_strap,
    input wire logic        charge_pulse,
    input wire logic        charge_active,
    input wire logic        discharge_pulse,
    input wire logic        self_discharge_pulse,
    input wire logic        early_empty_cross,
    input wire logic [15:0] available_charge_count,
    input wire logic [15:0] discharge_counter,
    input wire logic [15:0] learned_capacity,
    input wire logic        valid_charge_pulse,
    input wire logic        early_empty_flag,
    input wire logic        led_enable
);
    logic [2:0] up_cnt_reg;
    logic [7:0] hb;
    logic       up;
    assign hb = available_charge_count[15:8];
    assign up = (up_cnt_reg == 3'h5);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            up_cnt_reg <= 3'h0;
        end else if (!up) begin
            up_cnt_reg <= up_cnt_reg + 3'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!up);
    sequence s_display_control_strap_high;
        (display_control_strap == CAC_STRAP_HIGH) [*2];
    endsequence
    a_vc_carry: assert property (
        $past(charge_pulse && charge_active) && hb > $past(hb)
        |-> valid_charge_pulse) else $error("carry without valid charge");
    a_vc_cause: assert property (
        valid_charge_pulse |-> $past(charge_pulse && charge_active))
        else $error("valid charge without a charge count");
    a_nac_cap: assert property (
        available_charge_count <= learned_capacity)
        else $error("available charge above capacity");
    a_nac_floor: assert property (
        available_charge_count == CAC_ZERO && !charge_pulse
        |=> available_charge_count == CAC_ZERO) else $error("below zero");
    a_dcr_step: assert property (
        discharge_pulse && !charge_pulse && !self_discharge_pulse
        && !early_empty_flag && !early_empty_cross
        && discharge_counter != CAC_SAT_MAX
        && available_charge_count != learned_capacity
        |=> discharge_counter == $past(discharge_counter) + 16'h1)
        else $error("discharge counter missed a count");
    a_sd_empty: assert property (
        self_discharge_pulse && !discharge_pulse && !charge_pulse
        && available_charge_count == CAC_ZERO
        |=> $stable(discharge_counter)) else $error("self count when empty");
    a_dcr_full: assert property (
        available_charge_count == learned_capacity && !discharge_pulse
        && !self_discharge_pulse |=> discharge_counter == CAC_ZERO)
        else $error("discharge counter not cleared at full");
    a_empty_hold: assert property (
        early_empty_flag && !charge_pulse |=> early_empty_flag)
        else $error("early empty flag dropped");
    a_empty_set: assert property (
        early_empty_cross |-> ##[1:2] early_empty_flag)
        else $error("early empty flag not set");
    a_led_off: assert property (
        s_display_control_strap_high |-> !led_enable) else $error("display on while disabled");
endmodule
`default_nettype wire

// file: bench/cac_charge_counters_tb.sv
// testbench for the charge accounting counters
`timescale 1ns/1ps
`default_nettype none
module cac_charge_counters_tb;
    import cac_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [1:0]  strap_input_1 = 2'h0, strap_input_2 = 2'h0;
    logic [1:0]  strap_input_3 = 2'h0, strap_input_4 = 2'h0;
    logic [1:0]  strap_input_5 = 2'h0, kind = 2'h0;
    logic [1:0]  display_control_strap = CAC_STRAP_FLOAT;
    logic        fast_discharge = 1'b0, early_empty_cross = 1'b0;
    logic        end_voltage_cross = 1'b0, temp_below_zero = 1'b0;
    logic        start = 1'b0, slow = 1'b0, busy, charge_pulse;
    logic        discharge_pulse, self_discharge_pulse, charge_active;
    logic [15:0] burst = 16'h0, available_charge_count, discharge_counter;
    logic [15:0] learned_capacity, programmed_full_count;
    logic [2:0]  scale_select;
    logic [1:0]  self_discharge_rate;
    logic        valid_charge_pulse, valid_discharge_flag, led_enable;
    logic        early_empty_flag, end_voltage_flag;
    logic [15:0] pfc_tab [9] = '{16'h5800, 16'h6400, 16'h6c00, 16'h7800,
                               16'h8400, 16'h9000, 16'ha000, 16'hb000,
                               16'hc000};
    logic [3:0]  led_tab [4] = '{4'b1010, 4'b0001, 4'b0111, 4'b0100};
    int          miscompares = 0, samples_checked = 0, cycles = 0, vc_n = 0;
    cac_charge_counters i_dut (.*);
    cac_front_end_model i_fe (.*);
    always #2 sys_clk = ~sys_clk;
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (valid_charge_pulse === 1'b1) begin
            vc_n++;
        end
        if (++cycles > 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [1:0] k, input logic [15:0] n);
        @(negedge sys_clk);
        kind <= k;
        burst <= n;
        start <= 1'b1;
        @(negedge sys_clk);
        start <= 1'b0;
        do @(posedge sys_clk); while (busy === 1'b1);
        repeat (2) @(negedge sys_clk);
    endtask
    initial begin
        int sc;
        for (int i = 0; i < 9; i++) begin
            strap_input_1 = 2'(i / 3);
            strap_input_2 = 2'(i % 3);
            strap_input_3 = 2'(i % 3);
            strap_input_4 = (i < 5) ? CAC_STRAP_LOW : CAC_STRAP_FLOAT;
            strap_input_5 = 2'((i + 1) % 3);
            rst_b = 1'b0;
            repeat (12) @(negedge sys_clk);
            rst_b = 1'b1;
            repeat (6) @(negedge sys_clk);
            check(programmed_full_count, pfc_tab[i]);
            check(learned_capacity, pfc_tab[i]);
            sc = 2 - i % 3 + (i < 5 ? 0 : 3);
            check(16'(scale_select), 16'(sc));
            check(16'(self_discharge_rate), 16'(2 - (i + 1) % 3));
            check(available_charge_count, 16'h0);
        end
        run(2'h1, 16'd15);
        check(available_charge_count, 16'h00f0);
        check(16'(vc_n), 16'h0);
        run(2'h1, 16'd1);
        check(16'(vc_n), 16'h1);
        run(2'h2, 16'd1);
        check(discharge_counter, 16'h1);
        run(2'h1, 16'd15);
        check(16'(vc_n), 16'h1);
        run(2'h1, 16'd1);
        check(available_charge_count, 16'h0100);
        slow <= 1'b1;
        run(2'h1, 16'd3061);
        slow <= 1'b0;
        check(available_charge_count, 16'hc000);
        check(discharge_counter, 16'h0);
        check(16'(vc_n), 16'd193);
        run(2'h2, 16'd100);
        check(available_charge_count, 16'hb9c0);
        run(2'h3, 16'd10);
        check(discharge_counter, 16'd110);
        run(2'h2, 16'd3000);
        check(available_charge_count, 16'h0);
        check(discharge_counter, 16'd3110);
        run(2'h3, 16'd5);
        check(discharge_counter, 16'd3110);
        early_empty_cross <= 1'b1;
        end_voltage_cross <= 1'b1;
        @(negedge sys_clk);
        early_empty_cross <= 1'b0;
        end_voltage_cross <= 1'b0;
        run(2'h2, 16'd3);
        check({early_empty_flag, end_voltage_flag}, 16'h3);
        check(discharge_counter, 16'd3110);
        check(16'(valid_discharge_flag), 16'h1);
        run(2'h1, 16'd16);
        check(learned_capacity, 16'd3110);
        check(available_charge_count, 16'h0);
        check({early_empty_flag, end_voltage_flag}, 16'h0);
        run(2'h1, 16'd250);
        check(16'(valid_discharge_flag), 16'h1);
        temp_below_zero <= 1'b1;
        early_empty_cross <= 1'b1;
        @(negedge sys_clk);
        early_empty_cross <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check(16'(valid_discharge_flag), 16'h0);
        for (int j = 0; j < 4; j++) begin
            display_control_strap <= led_tab[j][3:2];
            fast_discharge <= led_tab[j][1];
            repeat (3) @(negedge sys_clk);
            check(16'(led_enable), 16'(led_tab[j][0]));
        end
        give_verdict();
    end
endmodule
bind cac_charge_counters cac_charge_counters_chk i_chk (.*);
`default_nettype wire

// file: bench/cac_front_end_model.sv
// front end model issuing compensated count pulses
`timescale 1ns/1ps
`default_nettype none
module cac_front_end_model (
    input  wire logic        sys_clk,
    input  wire logic [1:0]  kind,
    input  wire logic [15:0] burst,
    input  wire logic        start,
    input  wire logic        slow,
    output logic             busy,
    output logic             charge_pulse,
    output logic             discharge_pulse,
    output logic             self_discharge_pulse,
    output logic             charge_active
);
    logic [15:0] left_reg = 16'h0;
    logic        gap_reg = 1'b0;
    logic        fire;
    always @(negedge sys_clk) begin
        if (start) begin
            left_reg = burst;
        end
        gap_reg = slow && !gap_reg;
        fire = (left_reg != 16'h0) && !gap_reg;
        busy <= (left_reg != 16'h0);
        charge_active <= (kind == 2'h1) && (left_reg != 16'h0);
        charge_pulse <= fire && (kind == 2'h1);
        discharge_pulse <= fire && (kind == 2'h2);
        self_discharge_pulse <= fire && (kind == 2'h3);
        if (fire) begin
            left_reg = left_reg - 16'h1;
        end
    end
endmodule
`default_nettype wire

// file: rtl/cac_charge_counters.sv
// coulomb counting core: available charge, discharge count, capacity
//
// Summary of operation
// - charge adds, discharge and self-discharge subtract
// - counts arrive already compensated by front end
// - capacity learned only after clean full-empty discharge
// - init sets capacity to strap full count
// - before learning, charge stops at full count
// - sixteen-bit counter; high-byte carry flags valid charge
// - low byte cleared on down-to-up direction change
// - step size per increment set by scale
// - straps one and two select nine full counts
// - straps three and four select count scale
// - display strap sets led policy
// - available charge saturates at capacity, floor zero
// - counter cleared on init and valid charge after early-empty
// - discharge counter runs on until early-empty threshold
// - self-discharge feeds discharge counter only above zero
// - discharge counter clears at full, saturates ffff
// - qualified discharge copied to capacity on next charge
// - valid-discharge flag tracks qualification
// - charge window follows sense above charge threshold
// - charge counts scale with sense; display on
// - self-discharge strap selects rate or disables
// - empty flags latch until next valid charge
`timescale 1ns/1ps
`default_nettype none
module cac_charge_counters #(
    parameter int STEP_LOG_MAX = 3
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_b,
    input  wire logic [1:0]                 strap_input_1,
    input  wire logic [1:0]                 strap_input_2,
    input  wire logic [1:0]                 strap_input_3,
    input  wire logic [1:0]                 strap_input_4,
    input  wire logic [1:0]                 strap_input_5,
    input  wire logic [1:0]                 display_control_strap,
    input  wire logic                       charge_pulse,
    input  wire logic                       discharge_pulse,
    input  wire logic                       self_discharge_pulse,
    input  wire logic                       charge_active,
    input  wire logic                       fast_discharge,
    input  wire logic                       early_empty_cross,
    input  wire logic                       end_voltage_cross,
    input  wire logic                       temp_below_zero,
    output logic [cac_pkg::CAC_CNT_W-1:0]   available_charge_count,
    output logic [cac_pkg::CAC_CNT_W-1:0]   discharge_counter,
    output logic [cac_pkg::CAC_CNT_W-1:0]   learned_capacity,
    output logic [cac_pkg::CAC_CNT_W-1:0]   programmed_full_count,
    output logic [2:0]                      scale_select,
    output logic [1:0]                      self_discharge_rate,
    output logic                            valid_charge_pulse,
    output logic                            valid_discharge_flag,
    output logic                            early_empty_flag,
    output logic                            end_voltage_flag,
    output logic                            led_enable
);
    import cac_pkg::*;

    logic        rst_meta_reg;
    logic        rst_sync_reg;
    logic        init_done_reg;
    logic [15:0] nac_reg;
    logic [15:0] nac_next;
    logic [15:0] dcr_reg;
    logic [15:0] lmd_reg;
    logic [15:0] pfc_reg;
    logic [2:0]  scale_reg;
    logic [1:0]  sdr_reg;
    logic        learned_reg;
    logic        dir_up_reg;
    logic        vc_reg;
    logic        vdq_reg;
    logic        early_empty_flag_reg;
    logic        edv_reg;
    logic        led_reg;
    logic [12:0] sd_cnt_reg;
    logic        clear_on_vc_reg;
    cac_learn_type learn_reg;
    logic        carry;
    logic        up_step;
    logic        down_step;
    logic [16:0] step;
    logic [15:0] ceiling;
    logic        sd_on;
    logic        at_full;
    logic        dcr_count;

    function automatic logic [3:0] strap_idx(input logic [1:0] s);
        return (s == CAC_STRAP_HIGH) ? 4'h2 :
               (s == CAC_STRAP_FLOAT) ? 4'h1 : 4'h0;
    endfunction

    function automatic logic [15:0] pfc_lookup(input logic [1:0] a,
                                               input logic [1:0] b);
        logic [3:0] i;
        i = 4'((strap_idx(a) * 4'h3) + strap_idx(b));
        unique case (i)
            4'h0:    return CAC_PFC_LL;
            4'h1:    return CAC_PFC_LZ;
            4'h2:    return CAC_PFC_LH;
            4'h3:    return CAC_PFC_ZL;
            4'h4:    return CAC_PFC_ZZ;
            4'h5:    return CAC_PFC_ZH;
            4'h6:    return CAC_PFC_HL;
            4'h7:    return CAC_PFC_HZ;
            default: return CAC_PFC_HH;
        endcase
    endfunction

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // straps caught once after reset release
    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            init_done_reg <= 1'b0;
            pfc_reg       <= CAC_ZERO;
            scale_reg     <= CAC_SCALE_80;
            sdr_reg       <= CAC_SD_OFF;
        end else if (!init_done_reg) begin
            init_done_reg <= 1'b1;
            pfc_reg <= pfc_lookup(strap_input_1, strap_input_2);
            scale_reg <= 3'(((strap_input_4 == CAC_STRAP_FLOAT) ?
                             CAC_SCALE_640 : CAC_SCALE_80) +
                            ((strap_input_3 == CAC_STRAP_HIGH) ? 3'h0 :
                             (strap_input_3 == CAC_STRAP_FLOAT) ?
                             CAC_SCALE_STEP : 3'h2));
            sdr_reg <= (strap_input_5 == CAC_STRAP_HIGH) ? CAC_SD_OFF :
                       (strap_input_5 == CAC_STRAP_FLOAT) ? CAC_SD_DIV64 :
                       CAC_SD_DIV47;
        end
    end

    // step size grows with finer scale, capped
    always_comb begin
        step = 17'h00002 << ((scale_reg > 3'(STEP_LOG_MAX)) ?
                             3'(STEP_LOG_MAX) : scale_reg);
        ceiling = learned_reg ? lmd_reg : pfc_reg;
        at_full = (nac_reg == ceiling);
        // strap high drops self-discharge counts entirely
        sd_on   = (sdr_reg != CAC_SD_OFF);
        up_step   = charge_pulse && charge_active && init_done_reg;
        down_step = (discharge_pulse || (self_discharge_pulse && sd_on)) &&
                    !up_step && init_done_reg;
        // once empty, only real discharge still adds to the count
        dcr_count = init_done_reg &&
                    (discharge_pulse ||
                     (self_discharge_pulse && sd_on &&
                      nac_reg != CAC_ZERO));
        carry     = 1'b0;
        nac_next  = nac_reg;
        if (up_step) begin
            // low byte restarts when direction turns up
            nac_next = dir_up_reg ? nac_reg : {nac_reg[15:8], CAC_BYTE_ZERO};
            if ({1'b0, nac_next} + step >= {1'b0, ceiling}) begin
                nac_next = ceiling;
            end else begin
                nac_next = 16'({1'b0, nac_next} + step);
            end
            carry = nac_next[15:8] > nac_reg[15:8];
        end else if (down_step) begin
            nac_next = ({1'b0, nac_reg} > step) ?
                       16'({1'b0, nac_reg} - step) : CAC_ZERO;
        end
    end

    // available charge counter
    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            nac_reg    <= CAC_ZERO;
            dir_up_reg <= 1'b0;
            vc_reg     <= 1'b0;
        end else begin
            vc_reg <= carry;
            if (carry && clear_on_vc_reg) begin
                nac_reg <= CAC_ZERO;
            end else begin
                nac_reg <= nac_next;
            end
            if (up_step) begin
                dir_up_reg <= 1'b1;
            end else if (down_step) begin
                dir_up_reg <= 1'b0;
            end
        end
    end

    // empty flags latch until valid charge
    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            early_empty_flag_reg        <= 1'b0;
            clear_on_vc_reg <= 1'b0;
        end else begin
            early_empty_flag_reg <= early_empty_cross || (early_empty_flag_reg && !carry);
            // remembers the crossing until the clearing charge
            clear_on_vc_reg <= early_empty_cross ||
                               (clear_on_vc_reg && !carry);
        end
    end

    // final empty flag, set wins over the valid-charge clear
    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            edv_reg <= 1'b0;
        end else begin
            edv_reg <= end_voltage_cross || (edv_reg && !carry);
        end
    end

    // discharge counter
    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            dcr_reg <= CAC_ZERO;
        end else if (at_full && init_done_reg) begin
            // a count taken at full still lands, so none is lost
            if (dcr_count && !early_empty_flag_reg) begin
                dcr_reg <= 16'h0001;
            end else begin
                dcr_reg <= CAC_ZERO;
            end
        end else if (!early_empty_flag_reg && dcr_reg != CAC_SAT_MAX && dcr_count) begin
            dcr_reg <= dcr_reg + 16'h0001;
        end
    end

    // qualification and capacity learning
    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            learn_reg   <= CAC_ST_FULL_WAIT;
            vdq_reg     <= 1'b0;
            sd_cnt_reg  <= 13'h0000;
            lmd_reg     <= CAC_ZERO;
            learned_reg <= 1'b0;
        end else if (!init_done_reg) begin
            lmd_reg <= pfc_lookup(strap_input_1, strap_input_2);
        end else begin
            unique case (learn_reg)
                CAC_ST_FULL_WAIT: begin
                    if (at_full) begin
                        learn_reg  <= CAC_ST_DISCHARGE;
                        vdq_reg    <= 1'b1;
                        sd_cnt_reg <= 13'h0000;
                    end
                end
                CAC_ST_DISCHARGE: begin
                    // only enabled self-discharge counts weigh here, even those that drain nothing
                    if (self_discharge_pulse && sd_on &&
                        sd_cnt_reg != 13'h1fff) begin
                        sd_cnt_reg <= sd_cnt_reg + 13'h0001;
                    end
                    if (carry || sd_cnt_reg > CAC_SD_LIMIT) begin
                        vdq_reg   <= 1'b0;
                        learn_reg <= CAC_ST_FULL_WAIT;
                    end else if (early_empty_cross) begin
                        vdq_reg   <= !temp_below_zero;
                        learn_reg <= CAC_ST_EMPTY;
                    end
                end
                CAC_ST_EMPTY: begin
                    if (up_step) begin
                        if (vdq_reg) begin
                            lmd_reg     <= dcr_reg;
                            learned_reg <= 1'b1;
                        end
                        vdq_reg   <= 1'b0;
                        learn_reg <= CAC_ST_FULL_WAIT;
                    end
                end
            endcase
        end
    end

    // led policy
    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            led_reg <= 1'b0;
        end else begin
            led_reg <= (display_control_strap == CAC_STRAP_LOW) ||
                       (display_control_strap == CAC_STRAP_FLOAT &&
                        (charge_active || fast_discharge));
        end
    end

    assign available_charge_count = nac_reg;
    assign discharge_counter      = dcr_reg;
    assign learned_capacity       = lmd_reg;
    assign programmed_full_count  = pfc_reg;
    assign scale_select           = scale_reg;
    assign self_discharge_rate    = sdr_reg;
    assign valid_charge_pulse     = vc_reg;
    assign valid_discharge_flag   = vdq_reg;
    assign early_empty_flag       = early_empty_flag_reg;
    assign end_voltage_flag       = edv_reg;
    assign led_enable             = led_reg;
endmodule
`default_nettype wire

// file: rtl/cac_pkg.sv
// constants and types for the charge accounting counters
package cac_pkg;
    localparam int          CAC_CNT_W        = 16;
    localparam int          CAC_BYTE_W       = 8;
    localparam logic [15:0] CAC_ZERO         = 16'h0000;
    localparam logic [15:0] CAC_SAT_MAX      = 16'hffff;
    localparam logic [7:0]  CAC_BYTE_ZERO    = 8'h00;
    localparam logic [12:0] CAC_SD_LIMIT     = 13'h1000;
    // three-level strap codes
    localparam logic [1:0]  CAC_STRAP_LOW    = 2'h0;
    localparam logic [1:0]  CAC_STRAP_FLOAT  = 2'h1;
    localparam logic [1:0]  CAC_STRAP_HIGH   = 2'h2;
    // full count table, index = strap1*3 + strap2 (low=0, float=1, high=2)
    localparam logic [15:0] CAC_PFC_LL = 16'h5800;
    localparam logic [15:0] CAC_PFC_LZ = 16'h6400;
    localparam logic [15:0] CAC_PFC_LH = 16'h6c00;
    localparam logic [15:0] CAC_PFC_ZL = 16'h7800;
    localparam logic [15:0] CAC_PFC_ZZ = 16'h8400;
    localparam logic [15:0] CAC_PFC_ZH = 16'h9000;
    localparam logic [15:0] CAC_PFC_HL = 16'ha000;
    localparam logic [15:0] CAC_PFC_HZ = 16'hb000;
    localparam logic [15:0] CAC_PFC_HH = 16'hc000;
    // scale codes 0..5 = 1/80,1/160,1/320,1/640,1/1280,1/2560
    localparam logic [2:0]  CAC_SCALE_80     = 3'h0;
    localparam logic [2:0]  CAC_SCALE_640    = 3'h3;
    localparam logic [2:0]  CAC_SCALE_STEP   = 3'h1;
    // self-discharge rate codes
    localparam logic [1:0]  CAC_SD_OFF       = 2'h0;
    localparam logic [1:0]  CAC_SD_DIV64     = 2'h1;
    localparam logic [1:0]  CAC_SD_DIV47     = 2'h2;

    typedef enum logic [2:0] {
        CAC_ST_FULL_WAIT = 3'b001,
        CAC_ST_DISCHARGE = 3'b010,
        CAC_ST_EMPTY     = 3'b100
    } cac_learn_type;
endpackage
